// ===== hdl/iocs_pkg.sv
package iocs_pkg;
    localparam int NUM_SEL  = 7;
    localparam int NUM_INT  = 3;
    localparam int NUM_EXT  = 4;
    localparam int AW       = 16;
    localparam int WSW      = 3;
    localparam int IDXW     = 3;

    // Fixed decode used until the programmable mode bit is set.
    // Slots 0..2: serial A, serial B, printer
    // Slots 3..6: floppy, disk, disk control, spare
    localparam logic [AW-1:0]  DEF_BASE [NUM_SEL] = '{
        16'h03F8, 16'h02F8, 16'h0378, 16'h03F0,
        16'h01F0, 16'h03F6, 16'h0000};
    localparam logic [AW-1:0]  DEF_MASK [NUM_SEL] = '{
        16'h0007, 16'h0007, 16'h0007, 16'h0007,
        16'h0007, 16'h0001, 16'h0000};
    localparam logic [WSW-1:0] DEF_WAIT [NUM_SEL] = '{
        3'h1, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0};
    localparam logic [NUM_SEL-1:0] DEF_WIDE = 7'h10;
    localparam logic [NUM_SEL-1:0] DEF_EN   = 7'h3F;

    // Programmed slots start out disabled when standby power is first applied
    localparam logic [AW-1:0]  PRG_BASE_RST = 16'h0000;
    localparam logic [AW-1:0]  PRG_MASK_RST = 16'h0000;
    localparam logic [WSW-1:0] PRG_WAIT_RST = 3'h0;

    // Clock/RAM port, two bytes
    localparam logic [AW-1:0] CLK_PORT_HI   = 16'h0070;
    localparam logic [AW-1:0] CLK_PORT_LO   = 16'h0170;
    localparam logic [AW-1:0] CLK_PORT_MASK = 16'h0001;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_HOLD = 3'b100
    } iocs_state_t;
endpackage : iocs_pkg

// ===== hdl/iocs_slot.sv
module iocs_slot
    import iocs_pkg::*;
(
    input  wire logic [AW-1:0] addr,
    input  wire logic [AW-1:0] base,
    input  wire logic [AW-1:0] mask,
    input  wire logic          en,
    output logic               hit
);
    // Every one of the 16 bits takes part unless masked out
    assign hit = en && (((addr ^ base) & ~mask) == '0);
endmodule : iocs_slot

// ===== hdl/iocs_decoder.sv
module iocs_decoder
    import iocs_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic                stby_resetn,
    input  wire logic [AW-1:0]       io_addr,
    input  wire logic                io_rd_n,
    input  wire logic                io_wr_n,
    input  wire logic                clock_port_map_select,
    input  wire logic                mode_we,
    input  wire logic                mode_prog,
    input  wire logic                cfg_we,
    input  wire logic [IDXW-1:0]     cfg_index,
    input  wire logic [AW-1:0]       cfg_base,
    input  wire logic [AW-1:0]       cfg_mask,
    input  wire logic [WSW-1:0]      cfg_wait,
    input  wire logic                cfg_wide,
    input  wire logic                cfg_en,
    output logic [NUM_INT-1:0]       cs_int,
    output logic [NUM_EXT-1:0]       cs_ext_n,
    output logic                     clock_port_sel,
    output logic                     bus_wide,
    output logic                     io_ready,
    output logic                     prog_mode
);
    // Pin synchronisers
    logic [AW-1:0] addr_m, addr_q;
    logic [2:0]    pin_m, pin_q;
    logic          cyc, map_q;

    always_ff @(posedge clk) begin
        addr_m <= io_addr;
        addr_q <= addr_m;
        pin_m  <= {io_rd_n, io_wr_n, clock_port_map_select};
        pin_q  <= pin_m;
    end

    assign cyc   = !pin_q[2] || !pin_q[1];
    assign map_q = pin_q[0];

    // Standby-powered configuration, untouched by main reset
    logic [AW-1:0]      prg_base [NUM_SEL];
    logic [AW-1:0]      prg_mask [NUM_SEL];
    logic [WSW-1:0]     prg_wait [NUM_SEL];
    logic [NUM_SEL-1:0] prg_wide, prg_en;
    logic [AW-1:0]      next_prg_base [NUM_SEL];
    logic [AW-1:0]      next_prg_mask [NUM_SEL];
    logic [WSW-1:0]     next_prg_wait [NUM_SEL];
    logic [NUM_SEL-1:0] next_prg_wide, next_prg_en;

    always_comb begin
        next_prg_base = prg_base;
        next_prg_mask = prg_mask;
        next_prg_wait = prg_wait;
        next_prg_wide = prg_wide;
        next_prg_en   = prg_en;
        if (cfg_we && int'(cfg_index) < NUM_SEL) begin
            next_prg_base[cfg_index] = cfg_base;
            next_prg_mask[cfg_index] = cfg_mask;
            next_prg_wait[cfg_index] = cfg_wait;
            next_prg_wide[cfg_index] = cfg_wide;
            next_prg_en[cfg_index]   = cfg_en;
        end
    end

    always_ff @(posedge clk) begin
        if (!stby_resetn) begin
            for (int i = 0; i < NUM_SEL; i++) begin
                prg_base[i] <= PRG_BASE_RST;
                prg_mask[i] <= PRG_MASK_RST;
                prg_wait[i] <= PRG_WAIT_RST;
            end
            prg_wide <= '0;
            prg_en   <= '0;
        end else begin
            prg_base <= next_prg_base;
            prg_mask <= next_prg_mask;
            prg_wait <= next_prg_wait;
            prg_wide <= next_prg_wide;
            prg_en   <= next_prg_en;
        end
    end

    // Mode bit: default decode after every main reset
    logic next_prog_mode;

    always_comb begin
        next_prog_mode = mode_we ? mode_prog : prog_mode;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            prog_mode <= 1'b0;
        end else begin
            prog_mode <= next_prog_mode;
        end
    end

    // Effective decode per slot
    logic [AW-1:0]      eff_base [NUM_SEL];
    logic [AW-1:0]      eff_mask [NUM_SEL];
    logic [WSW-1:0]     eff_wait [NUM_SEL];
    logic [NUM_SEL-1:0] eff_wide, eff_en, hit;
    logic               clk_hit;

    for (genvar g = 0; g < NUM_SEL; g++) begin : g_slot
        assign eff_base[g] = prog_mode ? prg_base[g] : DEF_BASE[g];
        assign eff_mask[g] = prog_mode ? prg_mask[g] : DEF_MASK[g];
        assign eff_wait[g] = prog_mode ? prg_wait[g] : DEF_WAIT[g];
        assign eff_wide[g] = prog_mode ? prg_wide[g] : DEF_WIDE[g];
        assign eff_en[g]   = prog_mode ? prg_en[g]   : DEF_EN[g];
        iocs_slot u_slot (
            .addr (addr_q),
            .base (eff_base[g]),
            .mask (eff_mask[g]),
            .en   (eff_en[g]),
            .hit  (hit[g])
        );
    end

    iocs_slot u_clk_slot (
        .addr (addr_q),
        .base (map_q ? CLK_PORT_HI : CLK_PORT_LO),
        .mask (CLK_PORT_MASK),
        .en   (1'b1),
        .hit  (clk_hit)
    );

    // Lowest slot number sets wait and width when ranges overlap
    function automatic logic [IDXW-1:0] first_hit(
        input logic [NUM_SEL-1:0] h
    );
        first_hit = '0;
        for (int i = NUM_SEL - 1; i >= 0; i--) begin
            if (h[i]) first_hit = IDXW'(i);
        end
    endfunction : first_hit

    logic [IDXW-1:0] sel_idx;
    logic [WSW-1:0]  wsel;
    logic            wide_sel, go;

    assign sel_idx  = first_hit(hit);
    assign wsel     = eff_wait[sel_idx];
    assign wide_sel = eff_wide[sel_idx];

    // Selects and width
    logic [NUM_SEL-1:0] next_cs;
    logic               next_clk_sel, next_wide;

    always_comb begin
        next_cs      = cyc ? hit : '0;
        next_clk_sel = cyc && clk_hit;
        next_wide    = go ? wide_sel : (cyc && bus_wide);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cs_int         <= '0;
            cs_ext_n       <= '1;
            clock_port_sel <= 1'b0;
            bus_wide       <= 1'b0;
        end else begin
            cs_int         <= next_cs[NUM_INT-1:0];
            cs_ext_n       <= ~next_cs[NUM_SEL-1:NUM_INT];
            clock_port_sel <= next_clk_sel;
            bus_wide       <= next_wide;
        end
    end

    // Wait-state sequencer
    iocs_state_t    state, next_state;
    logic [WSW-1:0] cnt, next_cnt;
    logic           next_io_ready;

    assign go = (state == ST_IDLE) && cyc && (hit != '0);

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            ST_IDLE: begin
                if (go) begin
                    next_cnt   = wsel;
                    next_state = (wsel != '0) ? ST_WAIT : ST_HOLD;
                end
            end
            ST_WAIT: begin
                next_cnt = cnt - 3'h1;
                if (!cyc) begin
                    next_state = ST_IDLE;
                end else if (cnt == 3'h1) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!cyc) next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
        next_io_ready = (next_state != ST_WAIT);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state    <= ST_IDLE;
            cnt      <= '0;
            io_ready <= 1'b1;
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            io_ready <= next_io_ready;
        end
    end

    a_int_sel_cycle: assert property (
        @(posedge clk) disable iff (!resetn)
        (cs_int != '0) |-> $past(cyc))
        else $error("internal select without an I/O cycle");

    a_ext_sel_cycle: assert property (
        @(posedge clk) disable iff (!resetn)
        (cs_ext_n != '1)
            |-> $past(cyc && (hit[NUM_SEL-1:NUM_INT] != '0)))
        else $error("external select without cycle and hit");

    a_full_addr: assert property (
        @(posedge clk) disable iff (!resetn)
        cs_int[0]
            |-> $past(((addr_q ^ eff_base[0]) & ~eff_mask[0]) == '0))
        else $error("select 0 asserted on a partial address match");

    a_wait_zero: assert property (
        @(posedge clk) disable iff (!resetn)
        (go && wsel == 3'h0) |=> io_ready [*2])
        else $error("zero-wait access was stretched");

    a_wait_two: assert property (
        @(posedge clk) disable iff (!resetn)
        (go && wsel == 3'h2) ##1 cyc [*2] |-> !io_ready ##1 io_ready)
        else $error("two-wait access not stretched by two");

    a_width_hit: assert property (
        @(posedge clk) disable iff (!resetn)
        go |=> (bus_wide == $past(wide_sel)))
        else $error("width indication does not follow the hit select");

    a_default_reset: assert property (
        @(posedge clk)
        !resetn |=> !prog_mode)
        else $error("programmed decode active after reset");

    a_cfg_retained: assert property (
        @(posedge clk) disable iff (!stby_resetn)
        (!resetn && !cfg_we)
            |=> $stable(prg_base[0]) && $stable(prg_mask[0]))
        else $error("select configuration lost across main reset");

    a_clock_map: assert property (
        @(posedge clk) disable iff (!resetn)
        clock_port_sel |-> $past(cyc && (addr_q[AW-1:1]
            == (map_q ? CLK_PORT_HI[AW-1:1] : CLK_PORT_LO[AW-1:1]))))
        else $error("clock port decoded at the wrong address");
endmodule : iocs_decoder

// ===== testbench/iocs_host_model.sv
module iocs_host_model
    import iocs_pkg::*;
(
    input  wire logic          clk,
    output logic      [AW-1:0] io_addr,
    output logic               io_rd_n,
    output logic               io_wr_n
);
    timeunit 1ns;
    timeprecision 100ps;
    event answer;

    initial begin
        io_addr = 16'hFFFF;
        io_rd_n = 1'b1;
        io_wr_n = 1'b1;
    end

    // Kind 0 read, 1 write, 2 address with no strobe
    task automatic access(input logic [AW-1:0] a, input int kind);
        @(posedge clk);
        #1;
        io_addr = a;
        @(posedge clk);
        #1;
        io_rd_n = (kind != 0);
        io_wr_n = (kind != 1);
        repeat (3) @(posedge clk);
        #1;
        -> answer;
        repeat (9) @(posedge clk);
        #1;
        io_rd_n = 1'b1;
        io_wr_n = 1'b1;
        @(posedge clk);
        #1;
        // A released bus must not keep showing the last address
        io_addr = ~a;
        repeat (5) @(posedge clk);
    endtask : access
endmodule : iocs_host_model

// ===== testbench/iocs_decoder_bench.sv
module iocs_decoder_bench
    import iocs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic [AW-1:0]      io_addr, cfg_base, cfg_mask, rb, rk;
    logic [IDXW-1:0]    cfg_index;
    logic [WSW-1:0]     cfg_wait;
    logic [NUM_INT-1:0] cs_int;
    logic [NUM_EXT-1:0] cs_ext_n;
    logic               clk, resetn, stby_resetn, io_rd_n, io_wr_n;
    logic               clock_port_map_select, mode_we, mode_prog, cfg_we;
    logic               cfg_wide, cfg_en, clock_port_sel, bus_wide, io_ready;
    logic               prog_mode, m_mode, m_map;
    logic [AW-1:0]      m_base [NUM_SEL], m_mask [NUM_SEL];
    logic [WSW-1:0]     m_wait [NUM_SEL];
    logic [NUM_SEL-1:0] m_wide, m_en;
    logic [9:0]         exp_sel [$];
    logic [3:0]         exp_wait [$];
    int                 errors, n_checks, n, s, seed;

    iocs_host_model iocs_host_model_i (.clk, .io_addr, .io_rd_n, .io_wr_n);
    iocs_decoder iocs_decoder_i (.clk, .resetn, .stby_resetn, .io_addr,
        .io_rd_n, .io_wr_n, .clock_port_map_select, .mode_we, .mode_prog,
        .cfg_we, .cfg_index, .cfg_base, .cfg_mask, .cfg_wait, .cfg_wide,
        .cfg_en, .cs_int, .cs_ext_n, .clock_port_sel, .bus_wide, .io_ready,
        .prog_mode);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk_sel(input logic [9:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_sel

    task automatic chk_wait(input logic [3:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_wait

    // Expected decode: lowest hitting slot gives wait and width
    task automatic go(input logic [AW-1:0] a, input int kind);
        logic [NUM_SEL-1:0] hit;
        logic [AW-1:0]      b, k;
        logic               wd, cp;
        logic [3:0]         w;
        hit = '0;
        w = 4'h0;
        wd = 1'b0;
        for (int i = NUM_SEL - 1; i >= 0; i--) begin
            b = m_mode ? m_base[i] : DEF_BASE[i];
            k = m_mode ? m_mask[i] : DEF_MASK[i];
            if ((m_mode ? m_en[i] : DEF_EN[i]) && kind != 2
                && ((a ^ b) & ~k) == 16'h0000) begin
                hit[i] = 1'b1;
                w = {1'b0, m_mode ? m_wait[i] : DEF_WAIT[i]};
                wd = m_mode ? m_wide[i] : DEF_WIDE[i];
            end
        end
        cp = kind != 2 && (a & 16'hFFFE) == (m_map ? 16'h0070 : 16'h0170);
        exp_sel.push_back({m_mode, wd, cp, ~hit[6:3], hit[2:0]});
        exp_wait.push_back(w);
        iocs_host_model_i.access(a, kind);
    endtask : go

    task automatic cfg(input int sl, input logic [AW-1:0] b, k,
                       input logic [WSW-1:0] w, input logic wd, e);
        @(posedge clk);
        #1;
        {cfg_index, cfg_base, cfg_mask, cfg_wait} = {sl[2:0], b, k, w};
        {cfg_wide, cfg_en, cfg_we} = {wd, e, 1'b1};
        @(posedge clk);
        #1;
        cfg_we = 1'b0;
        if (sl < NUM_SEL) begin
            {m_base[sl], m_mask[sl], m_wait[sl]} = {b, k, w};
            {m_wide[sl], m_en[sl]} = {wd, e};
        end
    endtask : cfg

    task automatic set_mode(input logic v);
        @(posedge clk);
        #1;
        {mode_prog, mode_we} = {v, 1'b1};
        @(posedge clk);
        #1;
        mode_we = 1'b0;
        m_mode = v;
    endtask : set_mode

    task automatic do_reset(input logic main, stby);
        @(posedge clk);
        #1;
        {resetn, stby_resetn} = {~main, ~stby};
        repeat (2) @(posedge clk);
        #1;
        {resetn, stby_resetn} = 2'b11;
        if (main) m_mode = 1'b0;
        if (stby) {m_en, m_wide} = '0;
    endtask : do_reset

    initial forever begin
        @(iocs_host_model_i.answer);
        chk_sel({prog_mode, bus_wide, clock_port_sel, cs_ext_n,
                 cs_int}, exp_sel.pop_front());
        n = 0;
        while (io_ready === 1'b0 && n < 10) begin
            n++;
            @(posedge clk);
            #1;
        end
        chk_wait(n[3:0], exp_wait.pop_front());
    end

    initial begin
        #300000;
        errors++;
        finish_test();
    end

    initial begin
        {resetn, stby_resetn, mode_we, mode_prog, cfg_we, m_mode} = '0;
        {cfg_index, cfg_base, cfg_mask, cfg_wait, cfg_wide, cfg_en} = '0;
        {clock_port_map_select, m_map, m_en, m_wide} = {2'b11, 14'h0};
        {errors, n_checks} = '0;
        seed = $urandom(56145);
        repeat (2) @(posedge clk);
        #1;
        {resetn, stby_resetn} = 2'b11;
        for (int i = 0; i < NUM_SEL; i++) begin
            go(DEF_BASE[i] | DEF_MASK[i], i % 2);
            go((DEF_BASE[i] | DEF_MASK[i]) + 16'h0001, 0);
        end
        go(16'h83F8, 0);
        go(16'h03F8, 2);
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            #1;
            {clock_port_map_select, m_map} = {m[0], m[0]};
            for (int j = 0; j < 4; j++) begin
                go(16'h0070 | {j[1], 8'h00} | j[0], j % 2);
            end
        end
        cfg(7, 16'h0300, 16'h000F, 3'h7, 1'b1, 1'b1);
        cfg(0, 16'h0300, 16'h000F, 3'h2, 1'b1, 1'b1);
        go(16'h0305, 0);
        set_mode(1'b1);
        go(16'h0305, 0);
        go(16'h03F8, 1);
        for (int w = 0; w < 8; w++) begin
            rk = (16'h0001 << (w % 5)) - 16'h0001;
            rb = 16'($urandom);
            cfg(w % 7, rb, rk, w[2:0], w[0], 1'b1);
            go(rb ^ (16'($urandom) & rk), w % 2);
        end
        cfg(2, 16'h0300, 16'h0000, 3'h1, 1'b0, 1'b0);
        go(16'h0300, 0);
        repeat (16) begin
            s = $urandom % 7;
            go(m_base[s] ^ (16'($urandom) & m_mask[s]), $urandom % 2);
        end
        do_reset(1'b1, 1'b0);
        go(m_base[0], 0);
        set_mode(1'b1);
        go(m_base[0], 0);
        do_reset(1'b0, 1'b1);
        go(m_base[0], 0);
        finish_test();
    end
endmodule : iocs_decoder_bench
